// File: design/hib_pkg.sv
// package: register map, field positions and carriers for the hibernation power unit
// Contract
// - charger id inputs shown read-only at 28:24, zero without charger support
// - attach detect event bit 23 set on any attach event, write one clears; the code sets it only with power logic on
// - bit 22 mirrors phy b-session valid, trusted only with power logic on
// - bit 21 shows id pin, one device zero host, valid with logic on
// - bits 20:19 show line state 00,01 dp,10 dm,11 undefined
// - status change event bit 17 on id or session change, mask bit 18
// - session request event bit 15 on srp detect, mask bit 16
// - connect event bit 13 with mask 14, meaningful only under power option 2
// - disconnect event bit 11 with mask 12; software reinitializes after it
// - bus reset event bit 9 with mask 10, valid under power option 2
// - line change event bit 7 with mask 8 on line state change
// - supply switch bit 5: one off, zero on; not written in normal operation
// - core reset low bit 4 holds core in reset when zero
// - clamp bit 3 clamps all core outputs when one
// - restore bit 2 selects restore mode, valid under power option 2
// - software bit enables power logic; status reporting depends on it
// - power logic enable is bit 1, one enables
// - bit 0 routes power interrupt to software and blocks core interrupts
package hib_pkg;
    localparam logic [7:0] power_down_offset = 8'h58;
    localparam int charger_lsb = 24;
    localparam int attach_bit = 23;
    localparam int session_bit = 22;
    localparam int id_bit = 21;
    localparam int line_lsb = 19;
    localparam int status_mask_bit = 18;
    localparam int status_event_bit = 17;
    localparam int srp_mask_bit = 16;
    localparam int srp_event_bit = 15;
    localparam int connect_mask_bit = 14;
    localparam int connect_event_bit = 13;
    localparam int disconnect_mask_bit = 12;
    localparam int disconnect_event_bit = 11;
    localparam int bus_reset_mask_bit = 10;
    localparam int bus_reset_event_bit = 9;
    localparam int line_mask_bit = 8;
    localparam int line_event_bit = 7;
    localparam int session_ended_bit = 6;
    localparam int switch_bit = 5;
    localparam int core_reset_bit = 4;
    localparam int clamp_bit = 3;
    localparam int restore_bit = 2;
    localparam int enable_bit = 1;
    localparam int route_bit = 0;
    localparam logic [31:0] event_bits = 32'h0082_AA80;
    localparam logic [31:0] rw_bits = 32'h0005_557F;
    localparam logic [31:0] reset_value = 32'h0000_0000;
    localparam logic [1:0] power_option_hibernate = 2'h2;

    // status seen from the phy and the lines
    typedef struct packed {
        logic [4:0] charger_id;
        logic b_session_valid;
        logic id_pin;
        logic [1:0] line_state;
        logic attach_detect;
        logic srp_detect;
        logic connect_detect;
        logic disconnect_detect;
        logic bus_reset_detect;
    } phy_status_t;

    // controls driven toward the core power domain
    typedef struct packed {
        logic session_ended_flag;
        logic supply_switch_state;
        logic core_reset_low;
        logic output_clamp_enable;
        logic restore_mode;
        logic power_logic_enable;
        logic interrupt_route_select;
    } power_ctrl_t;
endpackage

// File: design/otg_hibernation_power_unit.sv
// otg_hibernation_power_unit: power-down register, event capture and core power controls
`timescale 1ns/1ps
module otg_hibernation_power_unit #(
    parameter bit charger_support_option = 1'b1,
    parameter logic [1:0] hibernation_power_option = 2'h2,
    parameter int core_out_width = 32
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // avalon-mm slave
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    output logic [1:0] response,
    // phy and line status
    input wire hib_pkg::phy_status_t phy_status,
    // core power domain
    input wire logic [core_out_width-1:0] core_outputs,
    input wire logic core_irq,
    output logic [core_out_width-1:0] clamped_outputs,
    output hib_pkg::power_ctrl_t power_ctrl,
    output logic power_irq,
    output logic app_irq
);
    logic [31:0] ctrl;
    logic [31:0] events;
    logic [31:0] rdata;
    logic done;
    logic prev_session;
    logic prev_id;
    logic [1:0] prev_line;
    logic [31:0] readdata_q;
    logic [1:0] response_q;

    wire hit = address == hib_pkg::power_down_offset;
    wire req = (read | write) & ~done;
    wire opt2 = hibernation_power_option == hib_pkg::power_option_hibernate;
    wire active = ctrl[hib_pkg::enable_bit];
    wire [31:0] be_mask = {{8{byteenable[3]}}, {8{byteenable[2]}},
                           {8{byteenable[1]}}, {8{byteenable[0]}}};
    // a write lands only at the edge where waitrequest is seen low
    wire wr_hit = write & hit & done;
    wire [31:0] clear_bits = wr_hit ? (writedata & be_mask & hib_pkg::event_bits)
                                    : 32'h0000_0000;

    // detections, each gated by the power logic being active
    wire status_change = active & ((phy_status.b_session_valid != prev_session)
                         | (phy_status.id_pin != prev_id));
    wire line_change = active & opt2 & (phy_status.line_state != prev_line);
    wire [31:0] set_bits = {8'h00,
        active & phy_status.attach_detect,
        5'h00, status_change, 1'b0,
        active & phy_status.srp_detect,
        1'b0, active & opt2 & phy_status.connect_detect,
        1'b0, active & opt2 & phy_status.disconnect_detect,
        1'b0, active & opt2 & phy_status.bus_reset_detect,
        1'b0, line_change, 7'h00};
    wire [31:0] next_events = (events & ~clear_bits) | set_bits;

    // masks placed one bit above each event they gate
    wire [31:0] pending = events & (ctrl >> 1) & hib_pkg::event_bits;
    wire [31:0] attach_pending = events & (32'h1 << hib_pkg::attach_bit);

    wire [31:0] status_bits = {3'b000,
        charger_support_option ? phy_status.charger_id : 5'h00,
        1'b0,
        phy_status.b_session_valid,
        phy_status.id_pin,
        phy_status.line_state,
        19'h00000};
    // without the hibernation option the option-2 masks and restore read zero
    wire [31:0] opt_bits = opt2 ? 32'hFFFF_FFFF : 32'h0005_007B;
    wire [31:0] rw_view = ctrl & hib_pkg::rw_bits & opt_bits;

    always_comb begin
        rdata = status_bits | events | rw_view;
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            done <= 1'b0;
        end else begin
            done <= req;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl <= hib_pkg::reset_value;
        end else if (wr_hit) begin
            ctrl <= (ctrl & ~(be_mask & hib_pkg::rw_bits))
                    | (writedata & be_mask & hib_pkg::rw_bits);
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            events <= hib_pkg::reset_value;
        end else begin
            events <= next_events;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            prev_session <= 1'b0;
            prev_id <= 1'b0;
            prev_line <= 2'b00;
        end else begin
            prev_session <= phy_status.b_session_valid;
            prev_id <= phy_status.id_pin;
            prev_line <= phy_status.line_state;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            readdata_q <= 32'h0000_0000;
            response_q <= 2'b00;
        end else if (req) begin
            readdata_q <= (read & hit) ? rdata : 32'h0000_0000;
            response_q <= hit ? 2'b00 : 2'b11;
        end
    end

    // one wait cycle; the answer stands on the cycle after
    assign waitrequest = (read | write) & ~done;
    assign readdata = readdata_q;
    assign response = response_q;

    // attach events interrupt even unmasked-less: no mask is defined for them
    assign power_irq = (|pending) | (|attach_pending);
    assign app_irq = ctrl[hib_pkg::route_bit] ? power_irq : core_irq;

    // clamps hold core outputs low so a dead domain cannot float into live logic
    assign clamped_outputs = ctrl[hib_pkg::clamp_bit] ? '0 : core_outputs;

    assign power_ctrl.session_ended_flag = ctrl[hib_pkg::session_ended_bit];
    assign power_ctrl.supply_switch_state = ctrl[hib_pkg::switch_bit];
    assign power_ctrl.core_reset_low = ctrl[hib_pkg::core_reset_bit];
    assign power_ctrl.output_clamp_enable = ctrl[hib_pkg::clamp_bit];
    assign power_ctrl.restore_mode = opt2 & ctrl[hib_pkg::restore_bit];
    assign power_ctrl.power_logic_enable = active;
    assign power_ctrl.interrupt_route_select = ctrl[hib_pkg::route_bit];
endmodule

// File: tb/hib_assertions.sv
// checker: bus answer, clamps, interrupt routing and status readback
`timescale 1ns/1ps
module hib_assertions #(
    parameter int core_out_width = 32
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic read,
    input wire logic write,
    input wire logic [7:0] address,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic [1:0] response,
    input wire hib_pkg::phy_status_t phy_status,
    input wire logic [core_out_width-1:0] core_outputs,
    input wire logic core_irq,
    input wire logic [core_out_width-1:0] clamped_outputs,
    input wire hib_pkg::power_ctrl_t power_ctrl,
    input wire logic power_irq,
    input wire logic app_irq
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire logic done = (read | write) & ~waitrequest;
    wire logic rd58 = done & read & (address == 8'h58);
    AST_CLAMP: assert property (power_ctrl.output_clamp_enable |-> clamped_outputs == '0)
        else $error("clamped outputs not zero");
    AST_PASS: assert property (!power_ctrl.output_clamp_enable |-> clamped_outputs == core_outputs)
        else $error("outputs not passed through");
    AST_ROUTE: assert property (app_irq == (power_ctrl.interrupt_route_select ? power_irq : core_irq))
        else $error("wrong interrupt routed");
    AST_WAIT: assert property ($rose(read | write) |-> waitrequest ##1 !waitrequest)
        else $error("answer not after one wait state");
    AST_UNMAPPED: assert property (done && address != 8'h58 |-> response == 2'b11 && readdata == '0)
        else $error("unmapped access not refused");
    AST_RESERVED: assert property (done && read |-> readdata[31:29] == 3'h0)
        else $error("reserved bits not zero");
    AST_CHARGER: assert property (rd58 |-> readdata[28:24] == $past(phy_status.charger_id))
        else $error("charger id readback wrong");
    AST_STATUS: assert property (rd58 |-> readdata[22:19] == $past({phy_status.b_session_valid, phy_status.id_pin, phy_status.line_state}))
        else $error("status readback wrong");
    AST_ATTACH: assert property (phy_status.attach_detect && power_ctrl.power_logic_enable |-> ##[1:2] power_irq)
        else $error("attach event did not interrupt");
    AST_IRQ_DROP: assert property ($fell(power_irq) |-> $past(write))
        else $error("interrupt dropped without a write");
    AST_CTRL: assert property (!$stable(power_ctrl) |-> $past(write))
        else $error("power controls changed without a write");
endmodule
bind otg_hibernation_power_unit hib_assertions #(.core_out_width(core_out_width)) chk (.*);

// File: tb/phy_model.sv
// phy side model: status levels and one-cycle detect pulses
`timescale 1ns/1ps
module phy_model (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // requested levels and pulses
    input wire logic [8:0] level,
    input wire logic [4:0] pulse,
    // toward the unit
    output hib_pkg::phy_status_t phy_status
);
    // a phy changes its status only just after an edge
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phy_status <= '0;
        end else begin
            phy_status <= {level, pulse};
        end
    end
endmodule

// File: tb/tb.sv
// testbench: register access, events, clamps and interrupt routing
`timescale 1ns/1ps
module tb;
    logic core_clk = 0, sys_rst = 1, read = 0, write = 0, core_irq = 1;
    logic [7:0] address = '0;
    logic [3:0] byteenable = 4'hF;
    logic [31:0] writedata = '0, readdata, core_outputs = 32'hA5A5_5A5A, clamped_outputs, q;
    logic [8:0] level = '0;
    logic [4:0] pulse = '0;
    logic waitrequest, power_irq, app_irq;
    logic [1:0] response;
    hib_pkg::phy_status_t phy_status;
    hib_pkg::power_ctrl_t power_ctrl;
    int n_mismatch = 0, n_compared = 0, cyc = 0;
    int ev[5] = '{23, 15, 13, 11, 9};
    logic [31:0] rw = hib_pkg::rw_bits;
    otg_hibernation_power_unit dut (.*);
    phy_model phy (.*);
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 3000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // the request stays up until waitrequest is seen low at an edge
    task automatic access(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge core_clk);
        address <= a;
        write <= w;
        read <= !w;
        writedata <= d;
        do @(posedge core_clk); while (waitrequest !== 1'b0);
        q = readdata;
        read <= 0;
        write <= 0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] exp);
        access(0, a, 0);
        check("readdata", q, exp);
    endtask
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        sys_rst <= 0;
        rd(8'h58, hib_pkg::reset_value);
        check("ctrl", 32'(power_ctrl), 0);
        access(1, 8'h58, '1);
        rd(8'h58, rw);
        check("ctrl", 32'(power_ctrl), 32'h7F);
        check("clamp", clamped_outputs, 0);
        check("app_irq", 32'(app_irq), 0);
        foreach (ev[i]) begin
            @(posedge core_clk);
            pulse <= 5'h10 >> i;
            @(posedge core_clk);
            pulse <= 0;
            rd(8'h58, rw | (1 << ev[i]));
            check("irq", 32'(power_irq), 1);
            access(1, 8'h58, rw | (1 << ev[i]));
            rd(8'h58, rw);
            check("irq", 32'(power_irq), 0);
        end
        level <= 9'h155;
        repeat (3) @(posedge core_clk);
        rd(8'h58, rw | 32'h152A_0080);
        check("irq", 32'(power_irq), 1);
        access(1, 8'h58, rw | hib_pkg::event_bits);
        rd(8'h58, rw | 32'h1528_0000);
        rd(8'h5C, 0);
        check("response", 32'(response), 32'h3);
        access(1, 8'h58, 0);
        @(negedge core_clk);
        check("clamp", clamped_outputs, core_outputs);
        check("app_irq", 32'(app_irq), 32'(core_irq));
        finish_test();
    end
endmodule
